// *** bench/srv_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module srv_ctl_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_start,
    input wire logic [3:0] delay,
    input wire logic qfull,
    input wire logic err,
    input wire logic [15:0] code,
    input wire logic [15:0] rsp_len,
    output logic ctl_done,
    output logic ctl_qfull,
    output logic ctl_err,
    output logic [15:0] ctl_err_code,
    output logic [15:0] ctl_rsp_len
);
    logic [4:0] cnt_q;
    logic busy_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
        end
        else
        begin
            cnt_q <= busy_q ? cnt_q - 5'h01 : {1'b0, delay};
            busy_q <= ctl_start | (busy_q & (cnt_q != 5'h00));
        end
    end
    assign ctl_done = busy_q & (cnt_q == 5'h00);
    // outcome lines only mean something with done, so they wander elsewhere
    assign ctl_qfull = ctl_done ? qfull : cnt_q[0];
    assign ctl_err = ctl_done ? err : cnt_q[1];
    assign ctl_err_code = ctl_done ? code : ~code;
    assign ctl_rsp_len = ctl_done ? rsp_len : ~rsp_len;
endmodule : srv_ctl_model
`default_nettype wire

// *** bench/test_srv_validator.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_srv_validator;
    logic clk = 0, rst_n = 0, attach_ok = 0, req_valid = 0, req_bcast = 0, buf_valid = 0;
    logic [4:0] ok5 = 0;
    logic [7:0] req_type = 0, req_next_type = 0, buf_type = 0, buf_next_type = 0, reg_addr = 0;
    logic [15:0] req_next_len = 0, req_data_len = 0, m_code = 0, m_len = 0, ec, ln;
    logic [31:0] reg_wdata = 0, reg_rdata, d;
    logic reg_wr = 0, reg_rd = 0, ctl_done, ctl_qfull, ctl_err, ctl_start, rsp_valid, rsp_data_ok;
    logic session_q, irq, m_q = 0, m_e = 0, started;
    logic [3:0] m_dly = 0;
    logic [7:0] rsp_major, rsp_minor;
    int fails = 0, checks_done = 0;
    always #4 clk = ~clk;
    srv_validator i_srv_validator (.clk(clk), .rst_n(rst_n), .attach_ok(attach_ok), .req_valid(req_valid),
        .req_type(req_type), .req_next_type(req_next_type), .req_next_len(req_next_len),
        .req_data_len(req_data_len), .req_bcast(req_bcast), .svc_supported(ok5[4]), .svc_bcast_ok(ok5[3]),
        .svc_priv_ok(ok5[2]), .mem_type_ok(ok5[1]), .mem_range_ok(ok5[0]), .buf_valid(buf_valid),
        .buf_type(buf_type), .buf_next_type(buf_next_type), .ctl_done(ctl_done), .ctl_qfull(ctl_qfull),
        .ctl_err(ctl_err), .ctl_err_code(ec), .ctl_rsp_len(ln), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl_start(ctl_start), .rsp_valid(rsp_valid),
        .rsp_major(rsp_major), .rsp_minor(rsp_minor), .rsp_data_ok(rsp_data_ok), .session_q(session_q), .irq(irq));
    srv_ctl_model i_srv_ctl_model (.clk(clk), .rst_n(rst_n), .ctl_start(ctl_start), .delay(m_dly), .qfull(m_q),
        .err(m_e), .code(m_code), .rsp_len(m_len), .ctl_done(ctl_done), .ctl_qfull(ctl_qfull), .ctl_err(ctl_err),
        .ctl_err_code(ec), .ctl_rsp_len(ln));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic run(input logic [7:0] t, nt, input logic [15:0] nl, dl, input logic [5:0] q,
        input logic [7:0] bt, bnt, exp);
        logic got;
        got = 0;
        started = 0;
        @(posedge clk);
        buf_valid <= 1'b0;
        {req_type, req_next_type, req_next_len, req_data_len, req_bcast, ok5} <= {t, nt, nl, dl, q};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        buf_valid <= dl > 16'h0002;
        {buf_type, buf_next_type} <= {bt, bnt};
        for (int i = 0; i < 60 && !got; i++)
        begin
            #1;
            started = started | (ctl_start === 1'b1);
            got = rsp_valid === 1'b1;
            if (got)
            begin
                check(rsp_minor, exp);
                check(rsp_major, exp == 8'h00 ? 8'h00 : 8'h0F);
                check(rsp_data_ok, exp == 8'h00);
            end
            else
            begin
                @(posedge clk);
                buf_valid <= 1'b0;
            end
        end
        check(got, 1'b1);
    endtask : run
    task automatic attach();
        @(posedge clk);
        attach_ok <= 1'b1;
        @(posedge clk);
        attach_ok <= 1'b0;
        #1 check(session_q, 1'b1);
    endtask : attach
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic t_request();
        run(8'h58, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h01);
        attach();
        run(8'h58, 8'h00, 0, 2, 6'h1F, 8'h54, 8'h00, 8'h00);
        run(8'h58, 8'h00, 0, 1, 6'h0F, 8'h54, 8'h00, 8'h01);
        run(8'h58, 8'h00, 0, 1, 6'h37, 8'h54, 8'h00, 8'h15);
        run(8'h58, 8'h00, 0, 1, 6'h1B, 8'h54, 8'h00, 8'h02);
        run(8'h58, 8'h00, 0, 1, 6'h1D, 8'h54, 8'h00, 8'h03);
        run(8'h58, 8'h00, 0, 1, 6'h1E, 8'h54, 8'h00, 8'h04);
        run(8'h58, 8'h00, 0, 0, 6'h1F, 8'h54, 8'h00, 8'h05);
        run(8'h58, 8'h54, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h21);
        check(session_q, 1'b0);
        run(8'h58, 8'h54, 1009, 1001, 6'h1F, 8'h54, 8'h00, 8'h21);
        attach();
        run(8'h58, 8'h54, 13, 4, 6'h1F, 8'h54, 8'h00, 8'h06);
        run(8'h58, 8'h54, 1008, 1000, 6'h1F, 8'h54, 8'h00, 8'h00);
        check(session_q, 1'b1);
    endtask : t_request
    task automatic t_fatal();
        run(8'h58, 8'h54, 12, 4, 6'h1F, 8'h55, 8'h00, 8'h22);
        check(started, 1'b0);
        check(session_q, 1'b0);
        attach();
        run(8'h58, 8'h54, 12, 4, 6'h1F, 8'h54, 8'h01, 8'h23);
        check(started, 1'b0);
        attach();
        run(8'h57, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h20);
        check(session_q, 1'b0);
        attach();
    endtask : t_fatal
    task automatic t_ctl();
        {m_q, m_dly} <= {1'b1, 4'h9};
        run(8'h58, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h07);
        {m_q, m_len} <= {1'b0, 16'd1001};
        run(8'h58, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h08);
        m_len <= 16'd1000;
        run(8'h58, 8'h54, 8, 3, 6'h1F, 8'h54, 8'h00, 8'h21);
        attach();
        run(8'h58, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h00);
        {m_e, m_code} <= {1'b1, 16'h1234};
        run(8'h58, 8'h00, 0, 1, 6'h1F, 8'h54, 8'h00, 8'h10);
        rd(8'h08);
        check(d[15:0], 16'h1234);
        rd(8'h0C);
        check(d[7:0], 8'h10);
        check(d[9:8], 2'h3);
        check(session_q, 1'b1);
    endtask : t_ctl
    task automatic t_irq();
        check(irq, 1'b0);
        wr(8'h04, 32'h0000_0001);
        rd(8'h00);
        check(d[2:0], 3'h7);
        check(irq, 1'b1);
        wr(8'h00, 32'h0000_0007);
        rd(8'h00);
        check(d[2:0], 3'h0);
        check(irq, 1'b0);
        rd(8'h10);
        check(d, 32'h0000_0000);
    endtask : t_irq
    initial
    begin
        // hang guard, far beyond the roughly 120 cycles the tests need
        #100000;
        fails++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 check({session_q, irq, rsp_valid, ctl_start}, 4'h0);
        t_request();
        t_fatal();
        t_ctl();
        t_irq();
        conclude();
    end
endmodule : test_srv_validator
`default_nettype wire

// *** src/srv_map.svh ***
`ifndef SRV_MAP_SVH
`define SRV_MAP_SVH
`define SRV_MAJOR_CODE 8'h0F
`define SRV_ERR_NONE 8'h00
`define SRV_ERR_SERVICE 8'h01
`define SRV_ERR_PRIV 8'h02
`define SRV_ERR_MEMTYPE 8'h03
`define SRV_ERR_RANGE 8'h04
`define SRV_ERR_LENGTH 8'h05
`define SRV_ERR_BUFLEN 8'h06
`define SRV_ERR_QFULL 8'h07
`define SRV_ERR_RSPLONG 8'h08
`define SRV_ERR_UNEXP 8'h10
`define SRV_ERR_BCAST 8'h15
`define SRV_ERR_REQTYPE 8'h20
`define SRV_ERR_REQNEXT 8'h21
`define SRV_ERR_BUFTYPE 8'h22
`define SRV_ERR_BUFNEXT 8'h23
`define SRV_FATAL_LO 8'h20
`define SRV_FATAL_HI 8'h23
`define SRV_TYPE_REQ 8'h58
`define SRV_TYPE_BUF 8'h54
`define SRV_MAX_DATA 16'h03E8
`define SRV_BUF_HDR 16'h0008
`define SRV_INLINE_MAX 16'h0002
`define SRV_BUF_MIN 16'h0009
`define SRV_BUF_MAX 16'h03F0
`define SRV_RETRY_MS 10
`define SRV_A_STAT 8'h00
`define SRV_A_MASK 8'h04
`define SRV_A_DIAG 8'h08
`define SRV_A_LAST 8'h0C
`endif

// *** src/srv_pkg.sv ***
package srv_pkg;
    typedef enum logic [3:0] {
        SRV_IDLE = 4'b0001,
        SRV_WBUF = 4'b0010,
        SRV_SERV = 4'b0100,
        SRV_WAIT = 4'b1000
    } srv_state_t;
endpackage : srv_pkg

// *** src/srv_validator.sv ***
// The implementer's own choices: strobed register access and the register offsets.
`include "srv_map.svh"
`timescale 1ns/1ps
`default_nettype none
module srv_validator
    import srv_pkg::*;
#(
    parameter int MAX_DATA = `SRV_MAX_DATA
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic attach_ok,
    input wire logic req_valid,
    input wire logic [7:0] req_type,
    input wire logic [7:0] req_next_type,
    input wire logic [15:0] req_next_len,
    input wire logic [15:0] req_data_len,
    input wire logic req_bcast,
    input wire logic svc_supported,
    input wire logic svc_bcast_ok,
    input wire logic svc_priv_ok,
    input wire logic mem_type_ok,
    input wire logic mem_range_ok,
    input wire logic buf_valid,
    input wire logic [7:0] buf_type,
    input wire logic [7:0] buf_next_type,
    input wire logic ctl_done,
    input wire logic ctl_qfull,
    input wire logic ctl_err,
    input wire logic [15:0] ctl_err_code,
    input wire logic [15:0] ctl_rsp_len,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic ctl_start,
    output logic rsp_valid,
    output logic [7:0] rsp_major,
    output logic [7:0] rsp_minor,
    output logic rsp_data_ok,
    output logic session_q,
    output logic irq
);
    localparam logic [7:0] A_STAT = `SRV_A_STAT;
    localparam logic [7:0] A_MASK = `SRV_A_MASK;
    localparam logic [7:0] A_DIAG = `SRV_A_DIAG;
    localparam logic [7:0] A_LAST = `SRV_A_LAST;

    if (MAX_DATA < 1 || MAX_DATA > `SRV_MAX_DATA)
    begin : g_bad_max
        $error("MAX_DATA out of range");
    end

    function automatic logic is_fatal(input logic [7:0] c);
        is_fatal = (c >= `SRV_FATAL_LO) && (c <= `SRV_FATAL_HI);
    endfunction : is_fatal

    srv_state_t st_q, st_d;
    logic [15:0] dlen_q, dlen_d;
    logic sess_d, start_d, rv_d, rok_d, irq_d;
    logic [7:0] minor_d, minor_q;
    logic [15:0] diag_q, diag_d;
    logic [2:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_d;
    logic [7:0] chk;

    // header checks, first hit wins; fatal framing first
    always_comb
    begin
        chk = `SRV_ERR_NONE;
        if (req_type != `SRV_TYPE_REQ)
            chk = `SRV_ERR_REQTYPE;
        else if (req_data_len <= `SRV_INLINE_MAX && req_next_type != 8'h00)
            chk = `SRV_ERR_REQNEXT;
        else if (req_data_len > `SRV_INLINE_MAX && (req_next_type != `SRV_TYPE_BUF
                 || req_next_len < `SRV_BUF_MIN || req_next_len > `SRV_BUF_MAX))
            chk = `SRV_ERR_REQNEXT;
        else if (!session_q || !svc_supported)
            chk = `SRV_ERR_SERVICE;
        else if (req_bcast && !svc_bcast_ok)
            chk = `SRV_ERR_BCAST;
        else if (!svc_priv_ok)
            chk = `SRV_ERR_PRIV;
        else if (!mem_type_ok)
            chk = `SRV_ERR_MEMTYPE;
        else if (!mem_range_ok)
            chk = `SRV_ERR_RANGE;
        else if (req_data_len == 16'h0000 || req_data_len > 16'(MAX_DATA))
            chk = `SRV_ERR_LENGTH;
        else if (req_data_len > `SRV_INLINE_MAX && req_next_len - `SRV_BUF_HDR != req_data_len)
            chk = `SRV_ERR_BUFLEN;
    end

    always_comb
    begin
        st_d = st_q;
        dlen_d = dlen_q;
        sess_d = session_q;
        start_d = 1'b0;
        rv_d = 1'b0;
        rok_d = 1'b0;
        minor_d = minor_q;
        diag_d = diag_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (attach_ok)
            sess_d = 1'b1;
        case (st_q)
            SRV_IDLE:
                if (req_valid)
                begin
                    if (chk != `SRV_ERR_NONE)
                    begin
                        rv_d = 1'b1;
                        minor_d = chk;
                    end
                    else if (req_data_len > `SRV_INLINE_MAX)
                    begin
                        dlen_d = req_data_len;
                        st_d = SRV_WBUF;
                    end
                    else
                    begin
                        start_d = 1'b1;
                        st_d = SRV_WAIT;
                    end
                end
            SRV_WBUF:
                if (buf_valid)
                begin
                    st_d = SRV_IDLE;
                    if (buf_type != `SRV_TYPE_BUF)
                    begin
                        rv_d = 1'b1;
                        minor_d = `SRV_ERR_BUFTYPE;
                    end
                    else if (buf_next_type != 8'h00)
                    begin
                        rv_d = 1'b1;
                        minor_d = `SRV_ERR_BUFNEXT;
                    end
                    else
                    begin
                        start_d = 1'b1;
                        st_d = SRV_WAIT;
                    end
                end
            SRV_SERV:
                st_d = SRV_IDLE;
            SRV_WAIT:
                if (ctl_done)
                begin
                    st_d = SRV_IDLE;
                    rv_d = 1'b1;
                    if (ctl_qfull)
                        minor_d = `SRV_ERR_QFULL;
                    else if (ctl_err)
                    begin
                        minor_d = `SRV_ERR_UNEXP;
                        diag_d = ctl_err_code;
                    end
                    else if (ctl_rsp_len > 16'(MAX_DATA))
                        minor_d = `SRV_ERR_RSPLONG;
                    else
                    begin
                        minor_d = `SRV_ERR_NONE;
                        rok_d = 1'b1;
                    end
                end
            default:
                st_d = SRV_IDLE;
        endcase
        // a fatal code ends the session; non-fatal codes leave it open
        if (rv_d && is_fatal(minor_d))
            sess_d = 1'b0;
        // status: bit0 non-fatal, bit1 fatal, bit2 ok; set wins over clear
        if (reg_wr && reg_addr == A_STAT)
            stat_d = stat_q & ~reg_wdata[2:0];
        if (reg_wr && reg_addr == A_MASK)
            mask_d = reg_wdata[2:0];
        if (rv_d)
            stat_d = stat_d | {rok_d, is_fatal(minor_d), !rok_d && !is_fatal(minor_d)};
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (reg_rd && reg_addr == A_STAT)
            rdata_d = {29'h0, stat_q};
        else if (reg_rd && reg_addr == A_MASK)
            rdata_d = {29'h0, mask_q};
        else if (reg_rd && reg_addr == A_DIAG)
            rdata_d = {16'h0, diag_q};
        else if (reg_rd && reg_addr == A_LAST)
            rdata_d = {22'h0, session_q, st_q == SRV_IDLE, minor_q};
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= SRV_IDLE;
            dlen_q <= 16'h0000;
            session_q <= 1'b0;
            ctl_start <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_major <= 8'h00;
            rsp_minor <= 8'h00;
            rsp_data_ok <= 1'b0;
            minor_q <= 8'h00;
            diag_q <= 16'h0000;
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            reg_rdata <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            dlen_q <= dlen_d;
            session_q <= sess_d;
            ctl_start <= start_d;
            rsp_valid <= rv_d;
            rsp_major <= (rv_d && !rok_d) ? `SRV_MAJOR_CODE : 8'h00;
            rsp_minor <= rv_d ? minor_d : 8'h00;
            rsp_data_ok <= rok_d;
            minor_q <= minor_d;
            diag_q <= diag_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            reg_rdata <= rdata_d;
            irq <= irq_d;
        end
    end

    property p_major;
        @(posedge clk) disable iff (!rst_n) rsp_valid && !rsp_data_ok |-> rsp_major == `SRV_MAJOR_CODE;
    endproperty
    a_major: assert property (p_major) else $error("major code wrong");
    property p_reqtype;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && req_type != `SRV_TYPE_REQ |=> rsp_valid && rsp_minor == `SRV_ERR_REQTYPE;
    endproperty
    a_reqtype: assert property (p_reqtype) else $error("bad request type not flagged");
    property p_nosess;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && chk == `SRV_ERR_SERVICE |=> rsp_minor == 8'h01 && !ctl_start;
    endproperty
    a_nosess: assert property (p_nosess) else $error("service error not flagged");
    property p_fatal;
        @(posedge clk) disable iff (!rst_n) rsp_valid && is_fatal(rsp_minor) && !$past(attach_ok) |-> !session_q;
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal code left session open");
    property p_nonfatal;
        @(posedge clk) disable iff (!rst_n)
            rsp_valid && rsp_minor inside {[8'h01:8'h15]} && $past(session_q) |-> session_q;
    endproperty
    a_nonfatal: assert property (p_nonfatal) else $error("non-fatal code closed session");
    property p_noside;
        @(posedge clk) disable iff (!rst_n) ctl_start |-> !rsp_valid;
    endproperty
    a_noside: assert property (p_noside) else $error("start with rejection");
    property p_buftype;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WBUF && buf_valid && buf_type != `SRV_TYPE_BUF |=> rsp_minor == `SRV_ERR_BUFTYPE ##1 st_q == SRV_IDLE;
    endproperty
    a_buftype: assert property (p_buftype) else $error("bad buffer type");
    property p_qfull;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WAIT && ctl_done && ctl_qfull |=> rsp_minor == `SRV_ERR_QFULL && !rsp_data_ok;
    endproperty
    a_qfull: assert property (p_qfull) else $error("queue full not flagged");

    // framing and gating restated on their own, for the assertions below
    logic frame_ok, gate_ok, sel_ok;
    assign frame_ok = req_type == `SRV_TYPE_REQ && (req_data_len <= `SRV_INLINE_MAX ? req_next_type == 8'h00
        : req_next_type == `SRV_TYPE_BUF && req_next_len >= `SRV_BUF_MIN && req_next_len <= `SRV_BUF_MAX);
    assign gate_ok = frame_ok && session_q && svc_supported && !(req_bcast && !svc_bcast_ok);
    assign sel_ok = gate_ok && svc_priv_ok && mem_type_ok && mem_range_ok;

    property p_reqnext;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && req_type == `SRV_TYPE_REQ && req_data_len <= `SRV_INLINE_MAX
            && req_next_type != 8'h00 |=> rsp_valid && rsp_minor == `SRV_ERR_REQNEXT;
    endproperty
    a_reqnext: assert property (p_reqnext) else $error("inline request with next type not flagged");
    property p_nextlen;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && req_type == `SRV_TYPE_REQ && req_data_len > `SRV_INLINE_MAX
            && (req_next_len < `SRV_BUF_MIN || req_next_len > `SRV_BUF_MAX)
            |=> rsp_valid && rsp_minor == `SRV_ERR_REQNEXT;
    endproperty
    a_nextlen: assert property (p_nextlen) else $error("buffer length out of range not flagged");
    property p_bcast;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && frame_ok && session_q && svc_supported && req_bcast && !svc_bcast_ok
            |=> rsp_valid && rsp_minor == `SRV_ERR_BCAST;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast refusal not flagged");
    property p_priv;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && gate_ok && !svc_priv_ok
            |=> rsp_valid && rsp_minor == `SRV_ERR_PRIV;
    endproperty
    a_priv: assert property (p_priv) else $error("privilege refusal not flagged");
    property p_memtype;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && gate_ok && svc_priv_ok && !mem_type_ok
            |=> rsp_valid && rsp_minor == `SRV_ERR_MEMTYPE;
    endproperty
    a_memtype: assert property (p_memtype) else $error("unknown memory type not flagged");
    property p_range;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && gate_ok && svc_priv_ok && mem_type_ok && !mem_range_ok
            |=> rsp_valid && rsp_minor == `SRV_ERR_RANGE;
    endproperty
    a_range: assert property (p_range) else $error("bad address range not flagged");
    property p_length;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && sel_ok && (req_data_len == 16'h0000 || req_data_len > 16'(MAX_DATA))
            |=> rsp_valid && rsp_minor == `SRV_ERR_LENGTH;
    endproperty
    a_length: assert property (p_length) else $error("bad data length not flagged");
    property p_buflen;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_IDLE && req_valid && sel_ok && req_data_len > `SRV_INLINE_MAX
            && req_data_len <= 16'(MAX_DATA) && req_next_len - `SRV_BUF_HDR != req_data_len
            |=> rsp_valid && rsp_minor == `SRV_ERR_BUFLEN;
    endproperty
    a_buflen: assert property (p_buflen) else $error("buffer length mismatch not flagged");
    property p_rsplong;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WAIT && ctl_done && !ctl_qfull && !ctl_err && ctl_rsp_len > 16'(MAX_DATA)
            |=> rsp_valid && rsp_minor == `SRV_ERR_RSPLONG && !rsp_data_ok;
    endproperty
    a_rsplong: assert property (p_rsplong) else $error("oversize response not flagged");
    property p_unexp;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WAIT && ctl_done && !ctl_qfull && ctl_err
            |=> rsp_minor == `SRV_ERR_UNEXP && diag_q == $past(ctl_err_code);
    endproperty
    a_unexp: assert property (p_unexp) else $error("controller error not saved");
    property p_bufnext;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WBUF && buf_valid && buf_type == `SRV_TYPE_BUF && buf_next_type != 8'h00
            |=> rsp_valid && rsp_minor == `SRV_ERR_BUFNEXT && !ctl_start;
    endproperty
    a_bufnext: assert property (p_bufnext) else $error("buffer next type not flagged");
    property p_bufstart;
        @(posedge clk) disable iff (!rst_n)
            st_q == SRV_WBUF && buf_valid && buf_type == `SRV_TYPE_BUF && buf_next_type == 8'h00
            |=> ctl_start && !rsp_valid && st_q == SRV_WAIT;
    endproperty
    a_bufstart: assert property (p_bufstart) else $error("clean buffer not passed on");
    property p_wbuflen;
        @(posedge clk) disable iff (!rst_n) st_q == SRV_WBUF |-> dlen_q > `SRV_INLINE_MAX;
    endproperty
    a_wbuflen: assert property (p_wbuflen) else $error("buffer wait without buffered length");
    property p_irq;
        @(posedge clk) disable iff (!rst_n) |(stat_q & mask_q) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_cov_ok;
        @(posedge clk) disable iff (!rst_n) rsp_valid && rsp_data_ok;
    endproperty
    c_ok: cover property (p_cov_ok);
    property p_cov_buf;
        @(posedge clk) disable iff (!rst_n) st_q == SRV_WBUF ##1 ctl_start;
    endproperty
    c_buf: cover property (p_cov_buf);
    property p_cov_fatal;
        @(posedge clk) disable iff (!rst_n) rsp_valid && rsp_minor == `SRV_ERR_REQNEXT;
    endproperty
    c_fatal: cover property (p_cov_fatal);
    property p_cov_unexp;
        @(posedge clk) disable iff (!rst_n) rsp_valid && rsp_minor == `SRV_ERR_UNEXP;
    endproperty
    c_unexp: cover property (p_cov_unexp);
endmodule : srv_validator
`default_nettype wire
